// >>> pmcs_pkg.sv
// Purpose: Shared constants and types for the port mode change sequencer
// Assumes: One switch core clock, AXI4-Lite software access
// Notes: Device byte addresses are those of the device-side access port
package pmcs_pkg;
  // ****************************************
  // Software register map
  // ****************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_GO = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STS = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;
  localparam logic [7:0] REG_PM_WORD = 8'h18;
  localparam logic [7:0] REG_VC_WORD = 8'h1C;
  localparam int CMD_PORT_LSB = 0;
  localparam int CMD_MODE_LSB = 4;
  localparam int CMD_ACT_LSB = 6;
  localparam int CMD_EE_BIT = 8;
  localparam int GO_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_LSB = 4;
  localparam int ST_SRC_LSB = 8;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_TMO = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ****************************************
  // Modes, actions, errors
  // ****************************************
  localparam logic [1:0] MODE_UNATT = 2'h0;
  localparam logic [1:0] MODE_UP = 2'h1;
  localparam logic [1:0] MODE_DN = 2'h2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_RESET = 2'h1;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_PART = 3'h1;
  localparam logic [2:0] ERR_PATH = 3'h2;
  localparam logic [2:0] ERR_REVERSE = 3'h3;
  localparam logic [2:0] ERR_ACTION = 3'h4;
  localparam logic [2:0] ERR_TIMEOUT = 3'h5;
  // ****************************************
  // Device side map and timing
  // ****************************************
  localparam logic [15:0] DEV_TMR_BASE = 16'h0100;
  localparam logic [15:0] DEV_TMR_STEP = 16'h0004;
  localparam logic [15:0] DEV_PORT_BASE = 16'h0200;
  localparam logic [15:0] DEV_PORT_STEP = 16'h0020;
  localparam logic [15:0] DEV_CTL_OFS = 16'h0000;
  localparam logic [15:0] DEV_STS_OFS = 16'h0004;
  localparam logic [15:0] DEV_PHY_OFS = 16'h0008;
  localparam logic [15:0] DEV_PM_OFS = 16'h000C;
  localparam logic [15:0] DEV_VC_OFS = 16'h0010;
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_ACT_LSB = 4;
  localparam int STS_DONE_BIT = 1;
  localparam int PHY_RETRAIN_BIT = 0;
  localparam logic [31:0] TMR_ZERO_VAL = 32'h0000_0000;
  localparam int NUM_TIMERS = 4;
  localparam int CLK_MHZ = 250;
  localparam int T_NOACT_US = 2000;
  localparam int T_RESET_US = 2500;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pmcs_dev_type;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_RD_CTL = 4'b0001, S_CHECK = 4'b0010, S_TMR_ZERO = 4'b0011,
    S_CAP_PM = 4'b0100, S_CAP_VC = 4'b0101, S_WR_CTL = 4'b0110, S_POLL = 4'b0111,
    S_RETRAIN = 4'b1000, S_TMR_RST = 4'b1001, S_DONE = 4'b1010, S_FAIL = 4'b1011
  } pmcs_state_type;
endpackage

// >>> pmcs_sequencer.sv
// Purpose: Host side sequencer that performs switch port mode changes
// Assumes: Device port answers each request with a one-cycle ack
// Notes: Refuses illegal changes after reading the control register, before any write to the device
// Summary of operation
// RULE_01: Loader path never polls the progress flags
// RULE_02: Loader zeroes four delay timers first
// RULE_03: Loader restores timer defaults last
// RULE_04: Loader path uses no-action only
// RULE_05: Loader allows only changes from unattached
// RULE_06: Write capability pointers before becoming upstream
// RULE_07: Poll done flag before anything further
// RULE_08: No upstream/downstream reversal until reset
// RULE_09: No mode change during partition state change
// RULE_10: No partition join during partition state change
// RULE_11: Unattached/downstream needs reset or retrained no-action; the loader path does not retrain after a no-action change
// RULE_12: Join under partition reset needs no-action
// RULE_13: Device sets started then done flag
// RULE_14: Change completes within 2 or 2.5 ms
// RULE_15: Device orders remove, add, action, done
// RULE_16: Per-port upstream/downstream history since reset
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
module pmcs_sequencer #(
  parameter int NUM_PORTS = 16,
  parameter int unsigned NOACT_CYC = pmcs_pkg::T_NOACT_US * pmcs_pkg::CLK_MHZ,
  parameter int unsigned RESET_CYC = pmcs_pkg::T_RESET_US * pmcs_pkg::CLK_MHZ,
  parameter logic [127:0] TMR_DEFAULTS = 128'h0000_0000_0000_0000_0000_0000_0000_0000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output pmcs_pkg::pmcs_dev_type dev_o,
  input wire logic dev_ack_i,
  input wire logic [31:0] dev_rdata_i,
  input wire logic part_state_busy_i,
  input wire logic partition_reset_pin_n_i,
  output logic irq_o
);
  // ****************************************
  // Software registers
  // ****************************************
  logic wr_take, rd_take, wr_fire, rd_fire, go;
  logic [31:0] wmask, cmd, pm_word, vc_word, rd_val;
  localparam int IRQ_W_L = pmcs_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_sts, irq_en, irq_set, irq_clr;
  logic wr_map, rd_map;
  pmcs_pkg::pmcs_state_type state;
  logic [3:0] port;
  logic [1:0] nmode, act, src, idx;
  logic ee, retrain;
  logic [2:0] err, chk_err;
  logic [31:0] tmo_cnt;
  logic [NUM_PORTS-1:0] was_up, was_dn;
  logic acc_done, need_cap, ud_pair, joining;
  logic acc_we;
  logic [15:0] acc_addr, pbase;
  logic [31:0] acc_data;

  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{s_axi_wstrb_i[b]}};
  end

  assign wr_fire = wr_take & s_axi_awvalid_i & s_axi_wvalid_i;
  assign rd_fire = rd_take & s_axi_arvalid_i;

  always_comb begin
    wr_map = 1'b0;
    if (s_axi_awaddr_i == pmcs_pkg::REG_CMD || s_axi_awaddr_i == pmcs_pkg::REG_GO) begin
      wr_map = 1'b1;
    end else if (s_axi_awaddr_i == pmcs_pkg::REG_IRQ_CLR) begin
      wr_map = 1'b1;
    end else if (s_axi_awaddr_i == pmcs_pkg::REG_IRQ_EN) begin
      wr_map = 1'b1;
    end else if (s_axi_awaddr_i == pmcs_pkg::REG_PM_WORD) begin
      wr_map = 1'b1;
    end else if (s_axi_awaddr_i == pmcs_pkg::REG_VC_WORD) begin
      wr_map = 1'b1;
    end
  end

  always_comb begin
    rd_map = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr_i == pmcs_pkg::REG_CMD) begin
      rd_val = cmd;
    end else if (s_axi_araddr_i == pmcs_pkg::REG_STATUS) begin
      rd_val[pmcs_pkg::ST_BUSY_BIT] = (state != pmcs_pkg::S_IDLE);
      rd_val[pmcs_pkg::ST_ERR_LSB +: 3] = err;
      rd_val[pmcs_pkg::ST_SRC_LSB +: 2] = src;
    end else if (s_axi_araddr_i == pmcs_pkg::REG_IRQ_STS) begin
      rd_val[IRQ_W_L-1:0] = irq_sts;
    end else if (s_axi_araddr_i == pmcs_pkg::REG_IRQ_EN) begin
      rd_val[IRQ_W_L-1:0] = irq_en;
    end else if (s_axi_araddr_i == pmcs_pkg::REG_PM_WORD) begin
      rd_val = pm_word;
    end else if (s_axi_araddr_i == pmcs_pkg::REG_VC_WORD) begin
      rd_val = vc_word;
    end else if (s_axi_araddr_i != pmcs_pkg::REG_GO && s_axi_araddr_i != pmcs_pkg::REG_IRQ_CLR) begin
      rd_map = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_take <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= pmcs_pkg::RESP_OKAY;
    end else begin
      wr_take <= s_axi_awvalid_i & s_axi_wvalid_i & ~wr_take & ~s_axi_bvalid_o;
      if (wr_fire) begin
        wr_take <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_map ? pmcs_pkg::RESP_OKAY : pmcs_pkg::RESP_DECERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end
  assign s_axi_awready_o = wr_take;
  assign s_axi_wready_o = wr_take;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_take <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= pmcs_pkg::RESP_OKAY;
    end else begin
      rd_take <= s_axi_arvalid_i & ~rd_take & ~s_axi_rvalid_o;
      if (rd_fire) begin
        rd_take <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_val;
        s_axi_rresp_o <= rd_map ? pmcs_pkg::RESP_OKAY : pmcs_pkg::RESP_DECERR;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
  assign s_axi_arready_o = rd_take;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd <= 32'h0000_0000;
      pm_word <= 32'h0000_0000;
      vc_word <= 32'h0000_0000;
      irq_en <= '0;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (wr_fire && s_axi_awaddr_i == pmcs_pkg::REG_CMD) begin
        cmd <= (cmd & ~wmask) | (s_axi_wdata_i & wmask);
      end else if (wr_fire && s_axi_awaddr_i == pmcs_pkg::REG_GO) begin
        go <= s_axi_wdata_i[pmcs_pkg::GO_BIT] & s_axi_wstrb_i[0];
      end else if (wr_fire && s_axi_awaddr_i == pmcs_pkg::REG_IRQ_EN) begin
        irq_en <= (irq_en & ~wmask[IRQ_W_L-1:0]) | (s_axi_wdata_i[IRQ_W_L-1:0] & wmask[IRQ_W_L-1:0]);
      end else if (wr_fire && s_axi_awaddr_i == pmcs_pkg::REG_PM_WORD) begin
        pm_word <= (pm_word & ~wmask) | (s_axi_wdata_i & wmask);
      end else if (wr_fire && s_axi_awaddr_i == pmcs_pkg::REG_VC_WORD) begin
        vc_word <= (vc_word & ~wmask) | (s_axi_wdata_i & wmask);
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_clr = (wr_fire && s_axi_awaddr_i == pmcs_pkg::REG_IRQ_CLR) ?
                   s_axi_wdata_i[IRQ_W_L-1:0] & wmask[IRQ_W_L-1:0] : '0;
  always_comb begin
    irq_set = '0;
    irq_set[pmcs_pkg::IRQ_DONE] = (state == pmcs_pkg::S_DONE);
    irq_set[pmcs_pkg::IRQ_ERR] = (state == pmcs_pkg::S_FAIL) && (err != pmcs_pkg::ERR_TIMEOUT);
    irq_set[pmcs_pkg::IRQ_TMO] = (state == pmcs_pkg::S_FAIL) && (err == pmcs_pkg::ERR_TIMEOUT);
  end
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_sts <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_sts <= (irq_sts & ~irq_clr) | irq_set;
      irq_o <= |(((irq_sts & ~irq_clr) | irq_set) & irq_en);
    end
  end

  // ****************************************
  // Checks before a change
  // ****************************************
  assign need_cap = (src == pmcs_pkg::MODE_UNATT) && (nmode == pmcs_pkg::MODE_UP);
  assign ud_pair = (src == pmcs_pkg::MODE_UNATT && nmode == pmcs_pkg::MODE_DN) ||
                   (src == pmcs_pkg::MODE_DN && nmode == pmcs_pkg::MODE_UNATT);
  assign joining = (nmode == pmcs_pkg::MODE_UP) || (nmode == pmcs_pkg::MODE_DN);
  always_comb begin
    chk_err = pmcs_pkg::ERR_NONE;
    if (part_state_busy_i) begin
      chk_err = pmcs_pkg::ERR_PART; // see RULE_09 RULE_10
    end else if (int'(port) >= NUM_PORTS) begin
      chk_err = pmcs_pkg::ERR_PATH;
    end else if (ee && (src != pmcs_pkg::MODE_UNATT || nmode == pmcs_pkg::MODE_UNATT)) begin
      chk_err = pmcs_pkg::ERR_PATH; // see RULE_05
    end else if (ee && act != pmcs_pkg::ACT_NONE) begin
      chk_err = pmcs_pkg::ERR_ACTION; // see RULE_04
    end else if ((nmode == pmcs_pkg::MODE_UP && (was_dn[port] || src == pmcs_pkg::MODE_DN)) ||
                 (nmode == pmcs_pkg::MODE_DN && (was_up[port] || src == pmcs_pkg::MODE_UP))) begin
      chk_err = pmcs_pkg::ERR_REVERSE; // see RULE_08
    end else if (ud_pair && act != pmcs_pkg::ACT_NONE && act != pmcs_pkg::ACT_RESET) begin
      chk_err = pmcs_pkg::ERR_ACTION; // see RULE_11
    end else if (!partition_reset_pin_n_i && joining && act != pmcs_pkg::ACT_NONE) begin
      chk_err = pmcs_pkg::ERR_ACTION; // see RULE_12
    end
  end

  // ****************************************
  // Device access
  // ****************************************
  assign pbase = 16'(pmcs_pkg::DEV_PORT_BASE + 16'(port) * pmcs_pkg::DEV_PORT_STEP);
  assign acc_done = dev_o.req & dev_ack_i;
  always_comb begin
    acc_we = 1'b1;
    acc_addr = pbase;
    acc_data = 32'h0000_0000;
    case (state)
      pmcs_pkg::S_RD_CTL: begin
        acc_we = 1'b0;
      end
      pmcs_pkg::S_TMR_ZERO: begin
        acc_addr = 16'(pmcs_pkg::DEV_TMR_BASE + 16'(idx) * pmcs_pkg::DEV_TMR_STEP);
        acc_data = pmcs_pkg::TMR_ZERO_VAL; // see RULE_02
      end
      pmcs_pkg::S_TMR_RST: begin
        acc_addr = 16'(pmcs_pkg::DEV_TMR_BASE + 16'(idx) * pmcs_pkg::DEV_TMR_STEP);
        acc_data = TMR_DEFAULTS[32*idx +: 32]; // see RULE_03
      end
      pmcs_pkg::S_CAP_PM: begin
        acc_addr = pbase + pmcs_pkg::DEV_PM_OFS;
        acc_data = pm_word;
      end
      pmcs_pkg::S_CAP_VC: begin
        acc_addr = pbase + pmcs_pkg::DEV_VC_OFS;
        acc_data = vc_word;
      end
      pmcs_pkg::S_WR_CTL: begin
        acc_data[pmcs_pkg::CTL_MODE_LSB +: 2] = nmode;
        acc_data[pmcs_pkg::CTL_ACT_LSB +: 2] = act;
      end
      pmcs_pkg::S_POLL: begin
        acc_we = 1'b0;
        acc_addr = pbase + pmcs_pkg::DEV_STS_OFS;
      end
      pmcs_pkg::S_RETRAIN: begin
        acc_addr = pbase + pmcs_pkg::DEV_PHY_OFS;
        acc_data[pmcs_pkg::PHY_RETRAIN_BIT] = 1'b1;
      end
      default: begin
        acc_we = 1'b1;
      end
    endcase
  end

  // Request held until acked; a new one starts only in an access state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dev_o <= '0;
    end else if (acc_done) begin
      dev_o.req <= 1'b0;
    end else if (!dev_o.req && state != pmcs_pkg::S_IDLE && state != pmcs_pkg::S_CHECK &&
                 state != pmcs_pkg::S_DONE && state != pmcs_pkg::S_FAIL) begin
      dev_o <= '{req: 1'b1, we: acc_we, addr: acc_addr, wdata: acc_data};
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= pmcs_pkg::S_IDLE;
      port <= 4'h0;
      nmode <= pmcs_pkg::MODE_UNATT;
      act <= pmcs_pkg::ACT_NONE;
      ee <= 1'b0;
      src <= pmcs_pkg::MODE_UNATT;
      idx <= 2'h0;
      err <= pmcs_pkg::ERR_NONE;
      tmo_cnt <= 32'h0000_0000;
    end else begin
      case (state)
        pmcs_pkg::S_IDLE: begin
          if (go) begin
            port <= cmd[pmcs_pkg::CMD_PORT_LSB +: 4];
            nmode <= cmd[pmcs_pkg::CMD_MODE_LSB +: 2];
            act <= cmd[pmcs_pkg::CMD_ACT_LSB +: 2];
            ee <= cmd[pmcs_pkg::CMD_EE_BIT];
            idx <= 2'h0;
            state <= pmcs_pkg::S_RD_CTL;
          end
        end
        pmcs_pkg::S_RD_CTL: begin
          if (acc_done) begin
            src <= dev_rdata_i[pmcs_pkg::CTL_MODE_LSB +: 2];
            state <= pmcs_pkg::S_CHECK;
          end
        end
        pmcs_pkg::S_CHECK: begin
          err <= chk_err;
          if (chk_err != pmcs_pkg::ERR_NONE) begin
            state <= pmcs_pkg::S_FAIL;
          end else if (ee) begin
            state <= pmcs_pkg::S_TMR_ZERO; // see RULE_02
          end else begin
            state <= need_cap ? pmcs_pkg::S_CAP_PM : pmcs_pkg::S_WR_CTL; // see RULE_06
          end
        end
        pmcs_pkg::S_TMR_ZERO: begin
          if (acc_done) begin
            idx <= idx + 2'h1;
            if (idx == 2'(pmcs_pkg::NUM_TIMERS - 1)) begin
              state <= need_cap ? pmcs_pkg::S_CAP_PM : pmcs_pkg::S_WR_CTL; // see RULE_06
            end
          end
        end
        pmcs_pkg::S_CAP_PM: begin
          if (acc_done) begin
            state <= pmcs_pkg::S_CAP_VC;
          end
        end
        pmcs_pkg::S_CAP_VC: begin
          if (acc_done) begin
            state <= pmcs_pkg::S_WR_CTL;
          end
        end
        pmcs_pkg::S_WR_CTL: begin
          tmo_cnt <= 32'h0000_0000;
          if (acc_done) begin
            // Progress flags are meaningless on the loader path
            state <= ee ? pmcs_pkg::S_TMR_RST : pmcs_pkg::S_POLL; // see RULE_01 RULE_03
          end
        end
        pmcs_pkg::S_POLL: begin
          tmo_cnt <= tmo_cnt + 32'h0000_0001;
          if (acc_done && dev_rdata_i[pmcs_pkg::STS_DONE_BIT]) begin
            state <= retrain ? pmcs_pkg::S_RETRAIN : pmcs_pkg::S_DONE; // see RULE_07 RULE_13
          end else if (!dev_o.req &&
                       tmo_cnt >= ((act == pmcs_pkg::ACT_RESET) ? RESET_CYC : NOACT_CYC)) begin
            err <= pmcs_pkg::ERR_TIMEOUT; // see RULE_14
            state <= pmcs_pkg::S_FAIL;
          end
        end
        pmcs_pkg::S_RETRAIN: begin
          if (acc_done) begin
            state <= pmcs_pkg::S_DONE;
          end
        end
        pmcs_pkg::S_TMR_RST: begin
          if (acc_done) begin
            idx <= idx + 2'h1;
            if (idx == 2'(pmcs_pkg::NUM_TIMERS - 1)) begin
              state <= pmcs_pkg::S_DONE;
            end
          end
        end
        default: begin
          state <= pmcs_pkg::S_IDLE;
        end
      endcase
    end
  end
  assign retrain = ud_pair && (act == pmcs_pkg::ACT_NONE); // see RULE_11

  // ****************************************
  // Port history
  // ****************************************
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_hist
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        was_up[p] <= 1'b0;
        was_dn[p] <= 1'b0;
      end else if (int'(port) == p) begin
        // Seen at read back and at a finished change; see RULE_16
        if ((state == pmcs_pkg::S_RD_CTL && acc_done &&
             dev_rdata_i[pmcs_pkg::CTL_MODE_LSB +: 2] == pmcs_pkg::MODE_UP) ||
            (state == pmcs_pkg::S_DONE && nmode == pmcs_pkg::MODE_UP)) begin
          was_up[p] <= 1'b1;
        end
        if ((state == pmcs_pkg::S_RD_CTL && acc_done &&
             dev_rdata_i[pmcs_pkg::CTL_MODE_LSB +: 2] == pmcs_pkg::MODE_DN) ||
            (state == pmcs_pkg::S_DONE && nmode == pmcs_pkg::MODE_DN)) begin
          was_dn[p] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_ee_no_poll: assert property (ee |-> state != pmcs_pkg::S_POLL) // see RULE_01
    else $error("loader path polled status");
  a_ee_tmr_first: assert property (state == pmcs_pkg::S_CHECK && ee && chk_err == pmcs_pkg::ERR_NONE
    |=> state == pmcs_pkg::S_TMR_ZERO && idx == 2'h0) // see RULE_02
    else $error("timers not zeroed first");
  a_ee_restore: assert property (state == pmcs_pkg::S_WR_CTL && ee && acc_done // see RULE_03
    |=> state == pmcs_pkg::S_TMR_RST && idx == 2'h0)
    else $error("timers not restored after change");
  a_ee_action: assert property (dev_o.req && state == pmcs_pkg::S_WR_CTL && ee
    |-> dev_o.wdata[pmcs_pkg::CTL_ACT_LSB +: 2] == pmcs_pkg::ACT_NONE) // see RULE_04
    else $error("loader change with an action");
  a_ee_source: assert property (state == pmcs_pkg::S_WR_CTL && ee
    |-> src == pmcs_pkg::MODE_UNATT && nmode != pmcs_pkg::MODE_UNATT) // see RULE_05
    else $error("loader change from attached mode");
  a_cap_first: assert property (state == pmcs_pkg::S_WR_CTL && need_cap
    |-> $past(state) inside {pmcs_pkg::S_CAP_VC, pmcs_pkg::S_WR_CTL}) // see RULE_06
    else $error("upstream change without pointers");
  a_poll_wait: assert property (state == pmcs_pkg::S_POLL && acc_done &&
    !dev_rdata_i[pmcs_pkg::STS_DONE_BIT] |=> state == pmcs_pkg::S_POLL) // see RULE_07
    else $error("left poll before done");
  a_no_reverse: assert property (state == pmcs_pkg::S_CHECK && !ee && // see RULE_08
    !part_state_busy_i && ((nmode == pmcs_pkg::MODE_UP && was_dn[port]) ||
    (nmode == pmcs_pkg::MODE_DN && was_up[port]))
    |=> state == pmcs_pkg::S_FAIL && err == pmcs_pkg::ERR_REVERSE)
    else $error("reversal not refused");
  a_part_busy: assert property (state == pmcs_pkg::S_CHECK && part_state_busy_i
    |=> state == pmcs_pkg::S_FAIL && err == pmcs_pkg::ERR_PART) // see RULE_09
    else $error("change during partition state change");
endmodule

// >>> pmcs_dev_model.sv
// Purpose: Device side model of the switch port registers
// Assumes: One request at a time, fields held until ack
// Notes: Ack delay follows address bits, so answers are prompt or slow
module pmcs_dev_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire pmcs_pkg::pmcs_dev_type dev_i,
  input wire logic [31:0] done_lat_i,
  output logic dev_ack_o,
  output logic [31:0] dev_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [15:0]];
  logic [15:0] wlog [$];
  int t_ctl [logic [15:0]];
  int cyc, dly, sts_rd;
  logic [15:0] a;
  assign a = dev_i.addr;
  // Started on control write, done after latency
  function automatic logic [31:0] rdv(logic [15:0] x);
    logic s;
    s = x >= 16'h0200 && x[4:0] == 5'h04 && t_ctl.exists(x - 16'h4);
    if (x >= 16'h0200 && x[4:0] == 5'h04)
      return {30'h0, s && cyc - t_ctl[x - 16'h4] >= int'(done_lat_i), s};
    return mem.exists(x) ? mem[x] : 32'h0;
  endfunction
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    dev_ack_o <= 1'b0;
    // Released data bus toggles so a stale word never looks valid
    dev_rdata_o <= ~dev_rdata_o;
    if (rst_i) begin
      mem.delete();
      wlog.delete();
      t_ctl.delete();
      dly <= 0;
      dev_rdata_o <= 32'h0;
    end else if (dev_i.req && !dev_ack_o) begin
      dly <= dly + 1;
      if (dly >= int'(a[3:2])) begin
        dly <= 0;
        dev_ack_o <= 1'b1;
        dev_rdata_o <= rdv(a);
        if (dev_i.we) begin
          mem[a] = dev_i.wdata;
          wlog.push_back(a);
          if (a >= 16'h0200 && a[4:0] == 5'h00) t_ctl[a] = cyc;
        end else if (a[4:0] == 5'h04) begin
          sts_rd <= sts_rd + 1;
        end
      end
    end
  end
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench of the port mode change sequencer
// Assumes: Device model on the far side, AXI4-Lite master tasks
// Notes: Short timeouts keep the run brief
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, rst_i = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic awr, wr, bv, arr, rv, ack, irq, busy = 0, prst_n = 1;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, drd, lat = 50, pmw, vcw, v;
  logic [1:0] br, rr, rs;
  pmcs_pkg::pmcs_dev_type dev;
  int failures = 0, checks = 0, seed = 32'h26af_fea6, k, s0, cur[16], hist[16];
  localparam logic [127:0] TD = 128'h0000_0044_0000_0033_0000_0022_0000_0011;
  always #2 clk_sys_i = ~clk_sys_i;
  pmcs_sequencer #(.NOACT_CYC(200), .RESET_CYC(250), .TMR_DEFAULTS(TD)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .dev_o(dev), .dev_ack_i(ack), .dev_rdata_i(drd), .part_state_busy_i(busy),
    .partition_reset_pin_n_i(prst_n), .irq_o(irq));
  pmcs_dev_model i_dev (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .dev_i(dev),
    .done_lat_i(lat), .dev_ack_o(ack), .dev_rdata_o(drd));
  task automatic print_verdict;
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk_sys_i);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (!bv);
    chk("bresp", 32'(br), 32'(pmcs_pkg::RESP_OKAY));
    bry <= 0;
    @(posedge clk_sys_i);
  endtask
  task automatic axr(logic [7:0] a);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge clk_sys_i);
      if (arr) arv <= 0;
    end while (!rv);
    v = rd;
    rs = rr;
    rry <= 0;
    @(posedge clk_sys_i);
  endtask
  // Reference outcome from the mode history kept here
  function automatic logic [2:0] xe(int p, int m, int a, int ee);
    if (busy) return pmcs_pkg::ERR_PART;
    if (ee && a != 0) return pmcs_pkg::ERR_ACTION;
    if (ee && cur[p] != 0) return pmcs_pkg::ERR_PATH;
    if (m * hist[p] == 2) return pmcs_pkg::ERR_REVERSE;
    if (!prst_n && a != 0) return pmcs_pkg::ERR_ACTION;
    return pmcs_pkg::ERR_NONE;
  endfunction
  task automatic chg(int p, int m, int a, int ee, int tmo);
    logic [2:0] e;
    axw(pmcs_pkg::REG_CMD, 32'(p + (m << 4) + (a << 6) + (ee << 8)));
    axw(pmcs_pkg::REG_GO, 32'h1);
    e = tmo ? pmcs_pkg::ERR_TIMEOUT : xe(p, m, a, ee);
    do axr(pmcs_pkg::REG_STATUS); while (v[0]);
    chk("err", 32'(v[6:4]), 32'(e));
    chk("src", 32'(v[9:8]), cur[p]);
    axr(pmcs_pkg::REG_IRQ_STS);
    chk("irq_sts", v, e == 0 ? 1 : e == 5 ? 4 : 2);
    chk("irq", 32'(irq), 1);
    axw(pmcs_pkg::REG_IRQ_CLR, 32'h7);
    chk("irq_clr", 32'(irq), 0);
    if (e == 0) cur[p] = m;
    if (e == 0 && m > 0 && m < 3) hist[p] = m;
  endtask
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 0;
    axr(8'h40);
    chk("decerr", 32'(rs), 32'(pmcs_pkg::RESP_DECERR));
    chk("decerr_data", v, 0);
    axr(pmcs_pkg::REG_IRQ_STS);
    chk("irq_rst", v, 0);
    axw(pmcs_pkg::REG_IRQ_EN, 32'h7);
    pmw = $random(seed);
    vcw = $random(seed);
    axw(pmcs_pkg::REG_PM_WORD, pmw);
    axw(pmcs_pkg::REG_VC_WORD, vcw);
    chg(1, 1, 0, 0, 0);
    chk("pm", i_dev.mem[16'h022C], pmw);
    chk("vc", i_dev.mem[16'h0230], vcw);
    chg(1, 2, 0, 0, 0);
    chg(1, 0, 0, 0, 0);
    chg(1, 2, 0, 0, 0);
    k = i_dev.wlog.size();
    s0 = i_dev.sts_rd;
    chg(2, 2, 0, 1, 0);
    chk("ee_poll", i_dev.sts_rd, s0);
    chk("ee_ctl", 32'(i_dev.wlog[k + 4]), 32'h0240);
    for (int i = 0; i < 4; i++) begin
      chk("tz", 32'(i_dev.wlog[k + i]), 32'h0100 + 4 * i);
      chk("td", i_dev.mem[16'h0100 + 4 * i], TD[32 * i +: 32]);
    end
    chg(3, 1, 1, 1, 0);
    chg(2, 0, 0, 1, 0);
    chg(4, 2, 0, 0, 0);
    chk("retrain", 32'(i_dev.mem[16'h0288][0]), 1);
    busy <= 1;
    chg(5, 1, 0, 0, 0);
    busy <= 0;
    prst_n <= 0;
    chg(5, 2, 1, 0, 0);
    chg(5, 2, 0, 0, 0);
    prst_n <= 1;
    lat <= 400;
    chg(6, 2, 1, 0, 1);
    rst_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 0;
    axw(pmcs_pkg::REG_IRQ_EN, 32'h7);
    cur = '{default: 0};
    hist = '{default: 0};
    lat <= 50;
    chg(1, 2, 1, 0, 0);
    print_verdict();
  end
endmodule
